// [include/ppc_pkg.sv]
// Constants, types and register map of the port pad configuration block
package ppc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int unsigned PPC_AW = 16;
  localparam int unsigned PPC_DW = 8;
  localparam int unsigned PPC_SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [PPC_AW-1:0] PPC_OFF_PULL_EN_H = 16'h0264;
  localparam logic [PPC_AW-1:0] PPC_OFF_PULL_POL_H = 16'h0265;
  localparam logic [PPC_AW-1:0] PPC_OFF_OPEN_DRAIN_H = 16'h0266;
  localparam logic [PPC_AW-1:0] PPC_OFF_RSVD_LO = 16'h0267;
  localparam logic [PPC_AW-1:0] PPC_OFF_RSVD_HI = 16'h0270;
  localparam logic [PPC_AW-1:0] PPC_OFF_AD_DATA = 16'h0271;
  localparam logic [PPC_AW-1:0] PPC_OFF_RSVD_AD0 = 16'h0272;
  localparam logic [PPC_AW-1:0] PPC_OFF_AD_DIR = 16'h0273;
  localparam logic [PPC_AW-1:0] PPC_OFF_RSVD_AD1 = 16'h0274;
  localparam logic [PPC_AW-1:0] PPC_OFF_AD_REDUCE = 16'h0275;
  localparam logic [PPC_AW-1:0] PPC_OFF_RSVD_AD2 = 16'h0276;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [PPC_DW-1:0] PPC_RST_PULL_EN_H = 8'hff;
  localparam logic [PPC_DW-1:0] PPC_RST_PULL_POL_H = 8'h00;
  localparam logic [PPC_DW-1:0] PPC_RST_OPEN_DRAIN_H = 8'h00;
  localparam logic [PPC_DW-1:0] PPC_RST_AD_DATA = 8'h00;
  localparam logic [PPC_DW-1:0] PPC_RST_AD_DIR = 8'h00;
  localparam logic [PPC_DW-1:0] PPC_RST_AD_REDUCE = 8'h00;
  localparam logic [PPC_DW-1:0] PPC_RSVD_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned PPC_DIR_SETTLE_CYC = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef logic [PPC_DW-1:0] ppc_byte_t;

  typedef struct packed {
    logic [PPC_AW-1:0] addr;
    ppc_byte_t wdata;
    logic wr;
    logic rd;
  } ppc_bus_req_s;

  typedef struct packed {
    ppc_byte_t out;
    ppc_byte_t oe;
    ppc_byte_t pull_up;
    ppc_byte_t pull_down;
  } ppc_port_h_pad_s;

  typedef struct packed {
    ppc_byte_t out;
    ppc_byte_t oe;
    ppc_byte_t reduced;
    ppc_byte_t in_en;
  } ppc_port_ad_pad_s;

  typedef enum logic [1:0] {
    PPC_RD_IDLE,
    PPC_RD_REG,
    PPC_RD_ZERO
  } ppc_rd_kind_e;

endpackage

// [verilog/ppc_sync.sv]
// Two-stage input synchronizer for pad input levels
`timescale 1ns/100ps
`default_nettype none
module ppc_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import ppc_pkg::*;

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // One flop pair per bit
  for (genvar g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
        meta_r[g] <= 1'b0;
        sync_r[g] <= 1'b0;
      end else begin
        meta_r[g] <= async_i[g];
        sync_r[g] <= meta_r[g];
      end
    end
  end

  assign sync_o = sync_r;

endmodule
`default_nettype wire

// [verilog/ppc_port_pad_config.sv]
// Pad control for port H pull and open-drain modes and the analog-shared port
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module ppc_port_pad_config (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire ppc_pkg::ppc_bus_req_s bus_i,
  output ppc_pkg::ppc_byte_t rdata_o,
  // Port H drive from the port data logic
  input wire ppc_pkg::ppc_byte_t ph_data_i,
  input wire ppc_pkg::ppc_byte_t ph_dir_i,
  // Port H pads
  output ppc_pkg::ppc_port_h_pad_s ph_pad_o,
  // Converter side of the analog-shared port
  input wire ppc_pkg::ppc_byte_t converter_input_sel_i,
  input wire ppc_pkg::ppc_byte_t converter_digital_input_enable_i,
  // Analog-shared port pads
  input wire ppc_pkg::ppc_byte_t ad_pin_i,
  output ppc_pkg::ppc_port_ad_pad_s ad_pad_o
);
  import ppc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic ppc_hit(input logic [PPC_AW-1:0] addr, input logic [PPC_AW-1:0] off);
    ppc_hit = (addr == off);
  endfunction

  function automatic logic ppc_is_rsvd(input logic [PPC_AW-1:0] addr);
    ppc_is_rsvd = ((addr >= PPC_OFF_RSVD_LO) && (addr <= PPC_OFF_RSVD_HI)) ||
                  (addr == PPC_OFF_RSVD_AD0) || (addr == PPC_OFF_RSVD_AD1) ||
                  (addr == PPC_OFF_RSVD_AD2);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  ppc_byte_t pull_enable_h_r;
  ppc_byte_t pull_polarity_select_h_r;
  ppc_byte_t open_drain_mode_h_r;
  ppc_byte_t analog_port_data_r;
  ppc_byte_t analog_port_direction_r;
  ppc_byte_t analog_port_drive_reduce_r;
  ppc_byte_t rdata_r;
  ppc_byte_t rdata_nxt;
  ppc_rd_kind_e rd_kind;

  ppc_byte_t ad_pin_sync;
  ppc_byte_t ad_gpio;
  ppc_byte_t ad_oe;
  ppc_byte_t ad_in_en;
  ppc_byte_t ad_readback;
  ppc_byte_t ph_oe;
  ppc_byte_t ph_out;

  ////////////////////////////////////////////////////////////////////////////
  // Port H pull enable
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pull_enable_h_r <= PPC_RST_PULL_EN_H;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_PULL_EN_H)) begin
      pull_enable_h_r <= bus_i.wdata;
    end
  end

  // Port H pull polarity
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pull_polarity_select_h_r <= PPC_RST_PULL_POL_H;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_PULL_POL_H)) begin
      pull_polarity_select_h_r <= bus_i.wdata;
    end
  end

  // Port H open-drain mode
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      open_drain_mode_h_r <= PPC_RST_OPEN_DRAIN_H;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_OPEN_DRAIN_H)) begin
      open_drain_mode_h_r <= bus_i.wdata;
    end
  end

  // Analog-shared port data
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      analog_port_data_r <= PPC_RST_AD_DATA;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_AD_DATA)) begin
      analog_port_data_r <= bus_i.wdata;
    end
  end

  // Analog-shared port direction
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      analog_port_direction_r <= PPC_RST_AD_DIR;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_AD_DIR)) begin
      analog_port_direction_r <= bus_i.wdata;
    end
  end

  // Analog-shared port reduced drive
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      analog_port_drive_reduce_r <= PPC_RST_AD_REDUCE;
    end else if (bus_i.wr && ppc_hit(bus_i.addr, PPC_OFF_AD_REDUCE)) begin
      analog_port_drive_reduce_r <= bus_i.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-shared pin input path
  ppc_sync #(
    .WIDTH(PPC_DW)
  ) u_ad_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(ad_pin_i),
    .sync_o(ad_pin_sync)
  );

  always_comb begin
    ad_gpio = ~converter_input_sel_i;
    ad_oe = ad_gpio & analog_port_direction_r;
    ad_in_en = ad_gpio & converter_digital_input_enable_i;
    // Input bits read the synchronized pin, so a direction change shows late
    ad_readback = (analog_port_direction_r & analog_port_data_r) |
                  (~analog_port_direction_r & ad_pin_sync & ad_in_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register readback
  always_comb begin
    rd_kind = PPC_RD_IDLE;
    if (bus_i.rd) begin
      rd_kind = ppc_is_rsvd(bus_i.addr) ? PPC_RD_ZERO : PPC_RD_REG;
    end
  end

  always_comb begin
    rdata_nxt = PPC_RSVD_READ;
    case (rd_kind)
      PPC_RD_REG: begin
        if (ppc_hit(bus_i.addr, PPC_OFF_PULL_EN_H)) begin
          rdata_nxt = pull_enable_h_r;
        end else if (ppc_hit(bus_i.addr, PPC_OFF_PULL_POL_H)) begin
          rdata_nxt = pull_polarity_select_h_r;
        end else if (ppc_hit(bus_i.addr, PPC_OFF_OPEN_DRAIN_H)) begin
          rdata_nxt = open_drain_mode_h_r;
        end else if (ppc_hit(bus_i.addr, PPC_OFF_AD_DATA)) begin
          rdata_nxt = ad_readback;
        end else if (ppc_hit(bus_i.addr, PPC_OFF_AD_DIR)) begin
          rdata_nxt = analog_port_direction_r;
        end else if (ppc_hit(bus_i.addr, PPC_OFF_AD_REDUCE)) begin
          rdata_nxt = analog_port_drive_reduce_r;
        end else begin
          rdata_nxt = PPC_RSVD_READ;
        end
      end
      PPC_RD_ZERO: begin
        rdata_nxt = PPC_RSVD_READ;
      end
      PPC_RD_IDLE: begin
        rdata_nxt = PPC_RSVD_READ;
      end
      default: begin
        rdata_nxt = PPC_RSVD_READ;
      end
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= PPC_RSVD_READ;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Port H output buffers
  always_comb begin
    // Open-drain bits drive low only; push-pull drives both levels
    ph_out = ph_data_i & ~open_drain_mode_h_r;
    ph_oe = ph_dir_i & (~open_drain_mode_h_r | ~ph_data_i);
  end

  // Port H pads
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ph_pad_o <= '0;
    end else begin
      ph_pad_o.out <= ph_out;
      ph_pad_o.oe <= ph_oe;
      ph_pad_o.pull_up <= pull_enable_h_r & ~pull_polarity_select_h_r & ~ph_dir_i;
      ph_pad_o.pull_down <= pull_enable_h_r & pull_polarity_select_h_r & ~ph_dir_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog-shared pads
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ad_pad_o <= '0;
    end else begin
      ad_pad_o.out <= analog_port_data_r & ad_oe;
      ad_pad_o.oe <= ad_oe;
      ad_pad_o.reduced <= analog_port_drive_reduce_r & ad_oe;
      ad_pad_o.in_en <= ad_in_en;
    end
  end

endmodule
`default_nettype wire

// [verification/ppc_port_pad_config_monitor.sv]
// Port-level assertions for the port pad configuration block
`timescale 1ns/100ps
`default_nettype none
module ppc_port_pad_config_monitor (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire ppc_pkg::ppc_bus_req_s bus_i,
  input wire ppc_pkg::ppc_byte_t rdata_o,
  // Port H
  input wire ppc_pkg::ppc_byte_t ph_data_i,
  input wire ppc_pkg::ppc_byte_t ph_dir_i,
  input wire ppc_pkg::ppc_port_h_pad_s ph_pad_o,
  // Analog-shared port
  input wire ppc_pkg::ppc_byte_t converter_input_sel_i,
  input wire ppc_pkg::ppc_byte_t converter_digital_input_enable_i,
  input wire ppc_pkg::ppc_byte_t ad_pin_i,
  input wire ppc_pkg::ppc_port_ad_pad_s ad_pad_o
);
  import ppc_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  AST_PULL_INPUT_ONLY: assert property (((ph_pad_o.pull_up | ph_pad_o.pull_down) & $past(ph_dir_i)) == 8'h00)
    else $error("pull device on an output pin");
  AST_PULL_ONE_KIND: assert property ((ph_pad_o.pull_up & ph_pad_o.pull_down) == 8'h00)
    else $error("pull-up and pull-down together");
  AST_OD_INPUT_IDLE: assert property ((ph_pad_o.oe & ~$past(ph_dir_i)) == 8'h00)
    else $error("port H input pin driven");
  AST_DRIVE_LOW: assert property (($past(ph_dir_i) & ~$past(ph_data_i) & ~(ph_pad_o.oe & ~ph_pad_o.out)) == 8'h00)
    else $error("port H low level not driven");
  AST_NO_HIGH_BEYOND_DATA: assert property ((ph_pad_o.out & ~$past(ph_data_i)) == 8'h00)
    else $error("port H high without data");
  AST_ANALOG_RELEASE: assert property (((ad_pad_o.oe | ad_pad_o.out | ad_pad_o.in_en) & $past(converter_input_sel_i)) == 8'h00)
    else $error("converter pin used as GPIO");
  AST_INPUT_ENABLE: assert property (ad_pad_o.in_en == (~$past(converter_input_sel_i) & $past(converter_digital_input_enable_i)))
    else $error("digital input enable wrong");
  AST_REDUCE_OUTPUT_ONLY: assert property (((ad_pad_o.reduced | ad_pad_o.out) & ~ad_pad_o.oe) == 8'h00)
    else $error("reduced drive or data on an input");
  AST_RSVD_ZERO: assert property (bus_i.rd && (bus_i.addr == PPC_OFF_RSVD_AD0 || bus_i.addr == PPC_OFF_RSVD_AD2) |=> rdata_o == 8'h00)
    else $error("reserved read not zero");
endmodule
`default_nettype wire

// [verification/ppc_board_model.sv]
// Board side of the analog-shared pins
`timescale 1ns/100ps
`default_nettype none
module ppc_board_model (
  // Pad drive and external level
  input wire ppc_pkg::ppc_port_ad_pad_s ad_pad_i,
  input wire ppc_pkg::ppc_byte_t ext_level_i,
  // Pin level
  output logic [7:0] pin_o
);
  // Driven pins follow the pad, released ones the board
  assign pin_o = (ad_pad_i.oe & ad_pad_i.out) | (~ad_pad_i.oe & ext_level_i);
endmodule
`default_nettype wire

// [verification/test_ppc_port_pad_config.sv]
// Self-checking bench for the port pad configuration block
`timescale 1ns/100ps
`default_nettype none
module test_ppc_port_pad_config;
  import ppc_pkg::*;
  logic clk_sys_i, rst_i, rd_d;
  ppc_bus_req_s bus;
  ppc_byte_t rdata, ph_data, ph_dir, sel, dien, ext, ad_pin, pe, pps, od, dat, dir, rdr;
  ppc_port_h_pad_s ph_pad;
  ppc_port_ad_pad_s ad_pad;
  ppc_byte_t q[$];
  logic [31:0] seed;
  int fail_count, n_tests;
  logic [15:0] offs [12];
  ////////////////////////////////////////////////////////////////////////////
  ppc_port_pad_config i_ppc_port_pad_config (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .ph_data_i(ph_data), .ph_dir_i(ph_dir), .ph_pad_o(ph_pad), .converter_input_sel_i(sel),
    .converter_digital_input_enable_i(dien), .ad_pin_i(ad_pin), .ad_pad_o(ad_pad));
  ppc_board_model i_ppc_board_model (.ad_pad_i(ad_pad), .ext_level_i(ext), .pin_o(ad_pin));
  ////////////////////////////////////////////////////////////////////////////
  function automatic ppc_byte_t rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
    return seed[15:8];
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    bus <= '0;
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [15:0] a, input ppc_byte_t d);
    bus <= '{a, d, 1'b1, 1'b0};
    case (a)
      PPC_OFF_PULL_EN_H: pe = d;
      PPC_OFF_PULL_POL_H: pps = d;
      PPC_OFF_OPEN_DRAIN_H: od = d;
      PPC_OFF_AD_DATA: dat = d;
      PPC_OFF_AD_DIR: dir = d;
      PPC_OFF_AD_REDUCE: rdr = d;
      default: ;
    endcase
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [15:0] a);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    case (a)
      PPC_OFF_PULL_EN_H: q.push_back(pe);
      PPC_OFF_PULL_POL_H: q.push_back(pps);
      PPC_OFF_OPEN_DRAIN_H: q.push_back(od);
      PPC_OFF_AD_DATA: q.push_back((dir & dat) | (~dir & ext & ~sel & dien));
      PPC_OFF_AD_DIR: q.push_back(dir);
      PPC_OFF_AD_REDUCE: q.push_back(rdr);
      default: q.push_back(PPC_RSVD_READ);
    endcase
    @(posedge clk_sys_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read data watcher
  always @(posedge clk_sys_i) rd_d <= bus.rd;
  always @(negedge clk_sys_i) begin
    if (rd_d === 1'b1) begin
      check({24'h0, rdata}, {24'h0, q.pop_front()});
    end
  end
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  initial begin
    seed = 32'hd61a;
    fail_count = 0;
    n_tests = 0;
    rst_i = 1'b1;
    bus = '0;
    {ph_data, ph_dir, sel, dien, ext} = '0;
    {pe, pps, od} = {PPC_RST_PULL_EN_H, PPC_RST_PULL_POL_H, PPC_RST_OPEN_DRAIN_H};
    {dat, dir, rdr} = {PPC_RST_AD_DATA, PPC_RST_AD_DIR, PPC_RST_AD_REDUCE};
    offs = '{PPC_OFF_PULL_EN_H, PPC_OFF_PULL_POL_H, PPC_OFF_OPEN_DRAIN_H, PPC_OFF_RSVD_LO, PPC_OFF_RSVD_HI,
      PPC_OFF_AD_DATA, PPC_OFF_RSVD_AD0, PPC_OFF_AD_DIR, PPC_OFF_RSVD_AD1, PPC_OFF_AD_REDUCE, PPC_OFF_RSVD_AD2, 16'h0300};
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    foreach (offs[i]) rd(offs[i]);
    idle(2);
    $display("Test reset values done");
    foreach (offs[i]) wr(offs[i], rnd());
    foreach (offs[i]) rd(offs[i]);
    idle(2);
    $display("Test register access done");
    repeat (32) begin
      ph_data <= rnd();
      ph_dir <= rnd();
      sel <= rnd() & rnd();
      dien <= rnd() | rnd();
      ext <= rnd();
      foreach (offs[i]) if (i < 3 || i == 5 || i == 7 || i == 9) wr(offs[i], rnd());
      idle(4);
      @(negedge clk_sys_i);
      check(ph_pad, {ph_data & ~od, ph_dir & (~od | ~ph_data), pe & ~pps & ~ph_dir, pe & pps & ~ph_dir});
      check(ad_pad, {dat & dir & ~sel, dir & ~sel, rdr & dir & ~sel, ~sel & dien});
      @(posedge clk_sys_i);
      rd(PPC_OFF_AD_DATA);
      idle(2);
    end
    $display("Test pad configurations done");
    finish_test();
  end
endmodule
bind ppc_port_pad_config ppc_port_pad_config_monitor i_ppc_port_pad_config_monitor (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .bus_i(bus_i), .rdata_o(rdata_o), .ph_data_i(ph_data_i), .ph_dir_i(ph_dir_i),
  .ph_pad_o(ph_pad_o), .converter_input_sel_i(converter_input_sel_i),
  .converter_digital_input_enable_i(converter_digital_input_enable_i), .ad_pin_i(ad_pin_i), .ad_pad_o(ad_pad_o));
`default_nettype wire
